/* File: inc/chan_cmp_if.sv */
// Carrier between the register bank and one channel level comparator.
// Assumes all signals are combinational within the hclk domain.
`timescale 1ns/1ps
interface chan_cmp_if #(
  parameter int CNT_W = 16
);
  logic [CNT_W-1:0] free_count;
  logic [CNT_W-1:0] flow_level;
  logic [CNT_W-1:0] low_level;
  logic             flow_hit;
  logic             low_hit;

  modport src (output free_count, output flow_level, output low_level,
               input flow_hit, input low_hit);
  modport cmp (input free_count, input flow_level, input low_level,
               output flow_hit, output low_hit);
endinterface

/* File: inc/mac_status_pkg.sv */
// Constants for the MAC status and emulation control register bank.
// Assumes a 32-bit AHB-Lite register bus and a 125 MHz clock.
package mac_status_pkg;

  // ==========================================================
  // Register map
  localparam int         ADDR_W        = 8;
  localparam logic [7:0] STATUS_OFF    = 8'h00;
  localparam logic [7:0] EMU_OFF       = 8'h04;
  localparam logic [7:0] RX_CTRL_OFF   = 8'h08;

  // ==========================================================
  // Status word fields
  localparam int ERRCH_LSB   = 8;
  localparam int ERRCH_MSB   = 10;
  localparam int GIG_BIT     = 4;
  localparam int DUPLEX_BIT  = 3;
  localparam int QOS_BIT     = 2;
  localparam int RXFLOW_BIT  = 1;
  localparam int TXPAUSE_BIT = 0;
  localparam logic [31:0] STATUS_RSV_MASK = 32'hFFFF_F8E0;

  // ==========================================================
  // Emulation control and receive control fields
  localparam int         EMU_SOFT_BIT   = 1;
  localparam int         EMU_FREE_BIT   = 0;
  localparam int         QOS_EN_BIT     = 0;
  localparam logic [1:0] EMU_RESET      = 2'h0;
  localparam logic [2:0] ERRCH_RESET    = 3'h0;
  localparam logic       QOS_EN_RESET   = 1'h0;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int QUANTUM_NS     = 512;
  localparam int QUANTUM_CYCLES = (QUANTUM_NS / CLK_PERIOD_NS < 1) ? 1
                                  : QUANTUM_NS / CLK_PERIOD_NS;
  localparam int QUANTA_W       = 16;

endpackage

/* File: logic/chan_level_cmp.sv */
// One receive channel free-buffer comparator.
// Assumes counts and levels are unsigned and stable within a cycle.
`timescale 1ns/1ps
module chan_level_cmp (
  chan_cmp_if.cmp c
);
  assign c.flow_hit = (c.free_count <= c.flow_level);
  assign c.low_hit  = (c.free_count <= c.low_level);
endmodule

/* File: logic/mac_status_emulation_ctrl.sv */
// MAC status word (low half) and emulation control, AHB-Lite slave.
// Assumes all inputs synchronous to hclk; zero wait-state bus.
// Notes on behaviour
// - Status bits 10:8 report error receive channel
// - Status read clears error channel field
// - Bit 4 mirrors external gigabit input
// - Bit 3 mirrors external full-duplex input
// - Bit 2: QoS enabled and count at/below low
// - Bit 1: a count at/below its flow level
// - Bit 0 high during received pause interval
// - No new frame start during pause, except pause
// - Frames already started run to completion
// - Emulation soft bit 1, free bit 0, reset 0
// - Host error flag held until hardware reset
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module mac_status_emulation_ctrl #(
  parameter int CHANNELS = 8,
  parameter int CNT_W    = 16
)(
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      ce,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  input  wire logic                      ext_gigabit_in,
  input  wire logic                      ext_duplex_in,
  input  wire logic [CHANNELS*CNT_W-1:0] chan_free_buf_count,
  input  wire logic [CHANNELS*CNT_W-1:0] chan_flow_level,
  input  wire logic [CNT_W-1:0]          rx_low_filter_level,
  input  wire logic                      rx_host_err,
  input  wire logic [2:0]                rx_host_err_chan,
  input  wire logic                      pause_frame_rx,
  input  wire logic [15:0]               pause_quanta,
  input  wire logic                      tx_start_req,
  input  wire logic                      tx_start_is_pause,
  output logic                           tx_start_grant,
  output logic                           rx_qos_active,
  output logic                           rx_flow_active,
  output logic                           tx_pause_active,
  output logic                           host_error_irq,
  output logic                           emu_soft,
  output logic                           emu_free
);

  // ==========================================================
  // State
  logic [2:0]   rx_error_channel_reg;
  logic         host_err_reg;
  logic [1:0]   emu_reg;
  logic         qos_en_reg;
  logic         qos_flag_reg;
  logic         flow_flag_reg;
  logic [15:0]  quanta_reg;
  logic [15:0]  sub_reg;
  logic         wr_pend_reg;
  logic [7:0]   wr_addr_reg;
  logic [31:0]  hrdata_reg;
  logic [31:0]  status_word;
  logic [31:0]  rd_word;
  logic [CHANNELS-1:0] flow_hits;
  logic [CHANNELS-1:0] low_hits;

  // ==========================================================
  // Channel comparators
  chan_cmp_if #(.CNT_W(CNT_W)) cmp_bus [CHANNELS] ();

  for (genvar i = 0; i < CHANNELS; i++)
  begin : g_chan
    assign cmp_bus[i].free_count = chan_free_buf_count[i*CNT_W +: CNT_W];
    assign cmp_bus[i].flow_level = chan_flow_level[i*CNT_W +: CNT_W];
    assign cmp_bus[i].low_level  = rx_low_filter_level;
    assign flow_hits[i]          = cmp_bus[i].flow_hit;
    assign low_hits[i]           = cmp_bus[i].low_hit;
    chan_level_cmp u_cmp (
      .c (cmp_bus[i])
    );
  end

  // ==========================================================
  // Bus decode
  wire         addr_phase = ce && hsel && hready && htrans[1];
  wire         rd_take    = addr_phase && !hwrite;
  wire         wr_take    = addr_phase && hwrite;
  wire [7:0]   rd_off     = haddr[mac_status_pkg::ADDR_W-1:0];
  wire         rd_status  = rd_take && (rd_off == mac_status_pkg::STATUS_OFF);
  wire         wr_done    = ce && wr_pend_reg;
  wire         wr_emu     = wr_done && (wr_addr_reg == mac_status_pkg::EMU_OFF);
  wire         wr_rxctrl  = wr_done && (wr_addr_reg == mac_status_pkg::RX_CTRL_OFF);
  wire         qos_next   = qos_en_reg && (|low_hits);
  wire         flow_next  = |flow_hits;

  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[mac_status_pkg::ERRCH_MSB:mac_status_pkg::ERRCH_LSB]
                = rx_error_channel_reg;
    status_word[mac_status_pkg::GIG_BIT]     = ext_gigabit_in;
    status_word[mac_status_pkg::DUPLEX_BIT]  = ext_duplex_in;
    status_word[mac_status_pkg::QOS_BIT]     = qos_flag_reg;
    status_word[mac_status_pkg::RXFLOW_BIT]  = flow_flag_reg;
    status_word[mac_status_pkg::TXPAUSE_BIT] = tx_pause_active;
  end

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (rd_off)
      mac_status_pkg::STATUS_OFF:  rd_word = status_word;
      mac_status_pkg::EMU_OFF:     rd_word = {30'h0000_0000, emu_reg};
      mac_status_pkg::RX_CTRL_OFF: rd_word = {31'h0000_0000, qos_en_reg};
      default:                     rd_word = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Bus registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      wr_pend_reg <= wr_take;
      if (wr_take)
        wr_addr_reg <= rd_off;
      if (rd_take)
        hrdata_reg <= rd_word;
    end
  end

  // Status writes are not decoded, so they change nothing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      emu_reg    <= mac_status_pkg::EMU_RESET;
      qos_en_reg <= mac_status_pkg::QOS_EN_RESET;
    end
    else
    begin
      if (wr_emu)
        emu_reg <= hwdata[1:0];
      if (wr_rxctrl)
        qos_en_reg <= hwdata[mac_status_pkg::QOS_EN_BIT];
    end
  end

  assign emu_soft = emu_reg[mac_status_pkg::EMU_SOFT_BIT];
  assign emu_free = emu_reg[mac_status_pkg::EMU_FREE_BIT];

  // ==========================================================
  // Host error capture; a new error beats a clearing read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_error_channel_reg <= mac_status_pkg::ERRCH_RESET;
      host_err_reg         <= 1'b0;
    end
    else if (ce)
    begin
      if (rx_host_err)
        rx_error_channel_reg <= rx_host_err_chan;
      else if (rd_status)
        rx_error_channel_reg <= mac_status_pkg::ERRCH_RESET;
      if (rx_host_err)
        host_err_reg <= 1'b1;
    end
  end

  assign host_error_irq = host_err_reg;

  // ==========================================================
  // Receive flow and QoS flags
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      qos_flag_reg  <= 1'b0;
      flow_flag_reg <= 1'b0;
    end
    else if (ce)
    begin
      qos_flag_reg  <= qos_next;
      flow_flag_reg <= flow_next;
    end
  end

  assign rx_qos_active  = qos_flag_reg;
  assign rx_flow_active = flow_flag_reg;

  // ==========================================================
  // Pause interval timer, one quantum per QUANTUM_CYCLES
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      quanta_reg <= 16'h0000;
      sub_reg    <= 16'h0000;
    end
    else if (ce)
    begin
      if (pause_frame_rx)
      begin
        quanta_reg <= pause_quanta;
        sub_reg    <= 16'(mac_status_pkg::QUANTUM_CYCLES - 1);
      end
      else if (quanta_reg != 16'h0000)
      begin
        if (sub_reg == 16'h0000)
        begin
          quanta_reg <= quanta_reg - 16'h0001;
          sub_reg    <= 16'(mac_status_pkg::QUANTUM_CYCLES - 1);
        end
        else
          sub_reg <= sub_reg - 16'h0001;
      end
    end
  end

  assign tx_pause_active = (quanta_reg != 16'h0000);

  // Only frame starts are gated; a running frame is never cut
  assign tx_start_grant = tx_start_req && (!tx_pause_active || tx_start_is_pause);

  // ==========================================================
  // Checks
  // Reference comparisons built straight from the ports
  logic chk_low_any;
  logic chk_flow_any;

  always_comb
  begin
    chk_low_any  = 1'b0;
    chk_flow_any = 1'b0;
    for (int j = 0; j < CHANNELS; j++)
    begin
      if (chan_free_buf_count[j*CNT_W +: CNT_W] <= rx_low_filter_level)
        chk_low_any = 1'b1;
      if (chan_free_buf_count[j*CNT_W +: CNT_W] <= chan_flow_level[j*CNT_W +: CNT_W])
        chk_flow_any = 1'b1;
    end
  end

  err_ch_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && rx_host_err |=> rx_error_channel_reg == $past(rx_host_err_chan))
    else $error("error channel not captured");

  err_ch_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_status && !rx_host_err |=> rx_error_channel_reg == 3'h0)
    else $error("error channel not cleared by read");

  gig_mirror_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_status |=> hrdata[mac_status_pkg::GIG_BIT] == $past(ext_gigabit_in))
    else $error("gigabit bit wrong");

  duplex_mirror_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_status |=> hrdata[mac_status_pkg::DUPLEX_BIT] == $past(ext_duplex_in))
    else $error("duplex bit wrong");

  qos_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce |=> rx_qos_active == ($past(qos_en_reg) && $past(chk_low_any)))
    else $error("qos flag wrong");

  flow_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce |=> rx_flow_active == $past(chk_flow_any))
    else $error("flow flag wrong");

  pause_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && pause_frame_rx && pause_quanta != 16'h0000 |=> tx_pause_active)
    else $error("pause not observed");

  no_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_pause_active && !tx_start_is_pause |-> !tx_start_grant)
    else $error("start granted during pause");

  emu_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_emu |=> emu_soft == $past(hwdata[1]) && emu_free == $past(hwdata[0]))
    else $error("emulation write lost");

  host_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
    host_error_irq |=> host_error_irq)
    else $error("host error flag dropped");

  reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_status |=> (hrdata & mac_status_pkg::STATUS_RSV_MASK) == 32'h0000_0000)
    else $error("reserved status bits not zero");

  pause_grant_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_start_req && tx_start_is_pause |-> tx_start_grant)
    else $error("pause frame start refused");

  free_grant_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !tx_pause_active |-> tx_start_grant == tx_start_req)
    else $error("start gated outside pause");

  pause_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !tx_pause_active && !pause_frame_rx |=> !tx_pause_active)
    else $error("pause began without a pause frame");

  emu_upper_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_take && rd_off == mac_status_pkg::EMU_OFF |=> hrdata[31:2] == 30'h0000_0000)
    else $error("emulation upper bits not zero");

  emu_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_emu |=> $stable(emu_reg))
    else $error("emulation bits changed without write");

  err_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !rx_host_err && !rd_status |=> $stable(rx_error_channel_reg))
    else $error("error channel changed without cause");

  irq_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && rx_host_err |=> host_error_irq)
    else $error("host error flag not set");

  qos_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !qos_en_reg |=> !rx_qos_active)
    else $error("qos flag set while disabled");

  bus_stall_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !ce |-> !hreadyout && !hresp)
    else $error("bus not stalled with clock enable low");

  ce_freeze_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !ce |=> $stable(emu_reg) && $stable(quanta_reg) && $stable(sub_reg)
            && $stable(rx_error_channel_reg) && $stable(hrdata_reg))
    else $error("state moved with clock enable low");

endmodule

/* File: verification/mac_status_emulation_ctrl_bench.sv */
// Self-checking bench for the MAC status and emulation control bank.
// Assumes the design's zero wait-state AHB-Lite slave, ce held high except in the clock enable stall check.
`timescale 1ns/1ps
module mac_status_emulation_ctrl_bench;
  localparam int CH = 8;
  localparam int CW = 16;
  logic           hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, rd_pend;
  logic [31:0]    haddr, hwdata, hrdata, wd;
  logic [1:0]     htrans;
  logic           ext_gigabit_in, ext_duplex_in, rx_host_err, pause_frame_rx;
  logic [2:0]     rx_host_err_chan;
  logic [15:0]    pause_quanta;
  logic [CW-1:0]  rx_low_filter_level;
  logic [CH*CW-1:0] chan_free_buf_count, chan_flow_level;
  logic           tx_start_req, tx_start_is_pause, tx_start_grant, rx_qos_active;
  logic           rx_flow_active, tx_pause_active, host_error_irq, emu_soft, emu_free;
  logic [31:0]    exp_q[$];
  int             error_cnt, n_checks, seed, k, n;

  mac_status_emulation_ctrl #(.CHANNELS(CH), .CNT_W(CW)) mac_status_emulation_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ext_gigabit_in(ext_gigabit_in), .ext_duplex_in(ext_duplex_in),
    .chan_free_buf_count(chan_free_buf_count), .chan_flow_level(chan_flow_level),
    .rx_low_filter_level(rx_low_filter_level), .rx_host_err(rx_host_err),
    .rx_host_err_chan(rx_host_err_chan), .pause_frame_rx(pause_frame_rx),
    .pause_quanta(pause_quanta), .tx_start_req(tx_start_req),
    .tx_start_is_pause(tx_start_is_pause), .tx_start_grant(tx_start_grant),
    .rx_qos_active(rx_qos_active), .rx_flow_active(rx_flow_active),
    .tx_pause_active(tx_pause_active), .host_error_irq(host_error_irq),
    .emu_soft(emu_soft), .emu_free(emu_free));

  always #4 hclk = ~hclk;

  // ==========================================================
  // Checking and closing
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Read results are compared against the oldest note
  always @(posedge hclk)
  begin
    if (rd_pend === 1'b1 && hreadyout === 1'b1)
    begin
      check("hrdata", exp_q.pop_front(), hrdata);
      check("hresp", 32'h0, {31'h0, hresp});
    end
  end

  // ==========================================================
  // Bus master
  task automatic wait_rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && i < 20)
    begin
      @(posedge hclk);
      i++;
    end
    if (hreadyout !== 1'b1)
    begin
      check("hreadyout", 32'h1, {31'h0, hreadyout});
      close_out;
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rd_pend <= !wr;
    if (!wr)
      exp_q.push_back(exp);
    wait_rdy;
    rd_pend <= 1'b0;
    hsel <= 1'b0;
  endtask

  function automatic logic [31:0] stat_word(input logic [2:0] ch, input logic [2:0] fl);
    stat_word = {21'h0, ch, 3'h0, ext_gigabit_in, ext_duplex_in, fl};
  endfunction

  // ==========================================================
  // Main sequence
  initial
  begin
    seed = 53839;
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
    rd_pend = 0; rx_host_err = 0; rx_host_err_chan = 0; pause_frame_rx = 0; ce = 1;
    pause_quanta = 0; tx_start_req = 0; tx_start_is_pause = 0; error_cnt = 0; n_checks = 0;
    ext_gigabit_in = $random(seed);
    ext_duplex_in = $random(seed);
    chan_free_buf_count = {CH{16'hFFFF}};
    chan_flow_level = {CH{16'h0100}};
    rx_low_filter_level = 16'h0080;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, mac_status_pkg::EMU_OFF, 0, 32'h0);
    bus(1, mac_status_pkg::STATUS_OFF, 32'hFFFF_FFFF, 0);
    bus(0, mac_status_pkg::STATUS_OFF, 0, stat_word(3'h0, 3'h0));
    bus(0, 8'h0C, 0, 32'h0);
    for (k = 0; k < 4; k++)
    begin
      wd = $random(seed);
      bus(1, mac_status_pkg::EMU_OFF, wd, 0);
      bus(0, mac_status_pkg::EMU_OFF, 0, {30'h0, wd[1:0]});
      check("emu", {30'h0, wd[1:0]}, {30'h0, emu_soft, emu_free});
    end
    for (k = 0; k < 8; k++)
    begin
      @(posedge hclk);
      rx_host_err <= 1'b1;
      rx_host_err_chan <= k[2:0];
      ext_gigabit_in <= $random(seed);
      ext_duplex_in <= $random(seed);
      @(posedge hclk);
      rx_host_err <= 1'b0;
      bus(0, mac_status_pkg::STATUS_OFF, 0, stat_word(k[2:0], 3'h0));
      bus(0, mac_status_pkg::STATUS_OFF, 0, stat_word(3'h0, 3'h0));
    end
    check("host_error_irq", 32'h1, {31'h0, host_error_irq});
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    check("host_error_irq", 32'h0, {31'h0, host_error_irq});
    check("emu", 32'h0, {30'h0, emu_soft, emu_free});
    hresetn <= 1'b1;
    bus(0, mac_status_pkg::EMU_OFF, 0, 32'h0);
    for (k = 0; k < CH; k++)
    begin
      chan_free_buf_count[k*CW +: CW] <= 16'h0100;
      repeat (2) @(posedge hclk);
      check("rx_flow_active", 32'h1, {31'h0, rx_flow_active});
      bus(0, mac_status_pkg::STATUS_OFF, 0, stat_word(3'h0, 3'h2));
      chan_free_buf_count[k*CW +: CW] <= 16'h0101;
      repeat (2) @(posedge hclk);
      check("rx_flow_active", 32'h0, {31'h0, rx_flow_active});
    end
    // Clock enable low stalls the bus and freezes the flags
    ce <= 1'b0;
    chan_free_buf_count[0 +: CW] <= 16'h0100;
    repeat (3) @(posedge hclk);
    check("hreadyout", 32'h0, {31'h0, hreadyout});
    check("rx_flow_active", 32'h0, {31'h0, rx_flow_active});
    ce <= 1'b1;
    repeat (2) @(posedge hclk);
    check("rx_flow_active", 32'h1, {31'h0, rx_flow_active});
    chan_free_buf_count[0 +: CW] <= 16'h0101;
    repeat (2) @(posedge hclk);
    chan_free_buf_count[3*CW +: CW] <= 16'h0080;
    repeat (2) @(posedge hclk);
    check("rx_qos_active", 32'h0, {31'h0, rx_qos_active});
    bus(1, mac_status_pkg::RX_CTRL_OFF, 32'h1, 0);
    repeat (2) @(posedge hclk);
    check("rx_qos_active", 32'h1, {31'h0, rx_qos_active});
    chan_free_buf_count[3*CW +: CW] <= 16'h0081;
    repeat (2) @(posedge hclk);
    check("rx_qos_active", 32'h0, {31'h0, rx_qos_active});
    for (k = 1; k < 3; k++)
    begin
      @(posedge hclk);
      pause_frame_rx <= 1'b1;
      pause_quanta <= k[15:0];
      tx_start_req <= 1'b1;
      tx_start_is_pause <= (k == 2);
      @(posedge hclk);
      pause_frame_rx <= 1'b0;
      #1;
      check("tx_start_grant", {31'h0, k == 2}, {31'h0, tx_start_grant});
      n = 0;
      while (tx_pause_active === 1'b1 && n < 300)
      begin
        @(posedge hclk);
        #1;
        n++;
      end
      check("pause_cycles", mac_status_pkg::QUANTUM_CYCLES * k, n);
      check("tx_start_grant", 32'h1, {31'h0, tx_start_grant});
    end
    repeat (2) @(posedge hclk);
    close_out;
  end
endmodule
